// file: bench/rsc_ctrl_asserts.sv
`timescale 1ns/1ps
// Watches the control outputs and the bus handshake of rsc_ctrl
module rsc_ctrl_asserts #(
    parameter [63:0] IDLE_CYC = 64'd50, // Keypad idle period in cycles
    parameter [63:0] HOLD_CYC = 64'd10 // Key hold period in cycles
) (
    input wire clk_i, // Clock
    input wire sys_rst_i, // Async reset, active high
    input wire enable_input_i, // Enable pin
    input wire stop_input_i, // Stop pin
    input wire trip_i, // Trip event
    input wire key_any_i, // Any key pressed
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire s_axi_rvalid, // Read data valid
    input wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire run_o, // Motor driven
    input wire coast_o, // Coast pulse
    input wire soft_stop_o, // Stop method pulse
    input wire trip_o, // Tripped
    input wire pref_view_o // Preferred view shown
);
    reg [63:0] idle_r; // Cycles since the last key activity
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Idle counter restarts on any key, so the return time is measurable
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_r <= 64'h0;
        end else if (key_any_i) begin // Key activity restarts the count
            idle_r <= 64'h0;
        end else begin
            idle_r <= idle_r + 64'h1;
        end
    end
    a_enable_blocks: assert property (!enable_input_i [*6] |-> !run_o)
        else $error("motor driven with enable open");
    a_coast_on_drop: assert property ($fell(enable_input_i) && run_o |-> ##[1:6] coast_o)
        else $error("no coast after enable dropped");
    a_stop_halts: assert property (!stop_input_i [*6] |-> !run_o)
        else $error("motor driven with stop open");
    a_stop_method: assert property ($fell(stop_input_i) && run_o |-> ##[1:6] soft_stop_o)
        else $error("no stop pulse after stop opened");
    a_start_interlock: assert property ($rose(run_o) |->
        $past(enable_input_i, 3) && $past(stop_input_i, 3))
        else $error("start without enable and stop closed");
    a_trip_sets: assert property (trip_i |-> ##[1:3] trip_o)
        else $error("trip event not latched");
    a_trip_no_drive: assert property (trip_o |=> !run_o)
        else $error("motor driven while tripped");
    a_view_returns: assert property (idle_r > IDLE_CYC + 64'd4 |-> pref_view_o)
        else $error("preferred view not restored after idle");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after taken");
    c_start: cover property ($rose(run_o));
    c_coast: cover property (coast_o);
    c_trip_clear: cover property ($fell(trip_o));
endmodule // rsc_ctrl_asserts

// file: bench/rsc_ctrl_tb.sv
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_ctrl_tb;
    logic clk_i, sys_rst_i, awv, wv, br, arv, rr; // Clock, reset, bus strobes
    logic [4:0] want; // Requested pin levels
    wire [4:0] pin; // Pin levels
    logic [9:0] pl; // Event pulses
    logic [2:0] kl; // Key levels: any toggle stopreset
    logic [7:0] awa, ara; // Bus addresses
    logic [31:0] wd, d; // Write data, read result
    wire awr, wrd, bv, arr, rv, run, rev, trip, pref; // Design outputs
    wire [1:0] bresp, rresp; // Responses
    wire [31:0] rdata; // Read data
    int errors, n_checks, i; // Counters
    int qi[4] = '{1234, 987, 45678, 15}; // Quantiser inputs
    int qe[4] = '{1230, 987, 45600, 15}; // Three significant digits
    rsc_pins_model u_pins (.clk_i(clk_i), .want_i(want), .pin_o(pin));
    rsc_ctrl #(.IDLE_CYC(64'd50), .HOLD_CYC(64'd10)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_forward_input_i(pin[0]),
        .run_reverse_input_i(pin[1]), .enable_input_i(pin[2]), .stop_input_i(pin[3]),
        .fourth_discrete_input_i(pin[4]), .trip_i(pl[0]), .key_any_i(kl[0]),
        .key_toggle_i(kl[1]), .key_stopreset_i(kl[2]), .key_reset_i(pl[2]),
        .key_run_fwd_i(pl[3]), .key_run_rev_i(pl[4]), .key_stop_i(pl[5]),
        .com_reset_i(pl[6]), .com_run_fwd_i(pl[7]), .com_run_rev_i(pl[8]),
        .com_stop_i(pl[9]), .autoreset_req_i(pl[1]), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .run_o(run), .reverse_o(rev), .coast_o(), .soft_stop_o(),
        .trip_o(trip), .pref_view_o(pref));
    // Compare and count
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Bus write; address and data released each at its own ready
    task axw(input [7:0] a, input [31:0] v, input [1:0] er);
        bit da, dw;
        da = 0;
        dw = 0;
        @(posedge clk_i);
        awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
        while (!(da && dw)) begin
            @(posedge clk_i);
            if (!da && awr === 1) begin da = 1; awv <= 0; end
            if (!dw && wrd === 1) begin dw = 1; wv <= 0; end
        end
        while (bv !== 1) @(posedge clk_i);
        chk("bresp", bresp, er);
        br <= 0;
    endtask
    // Bus read; data taken at the edge where rvalid is seen
    task axr(input [7:0] a, input [1:0] er);
        @(posedge clk_i);
        ara <= a; arv <= 1; rr <= 1;
        do @(posedge clk_i); while (arr !== 1);
        arv <= 0;
        while (rv !== 1) @(posedge clk_i);
        d = rdata;
        chk("rresp", rresp, er);
        rr <= 0;
    endtask
    // Set pin levels and let them pass the synchroniser
    task pins(input [4:0] v);
        @(posedge clk_i);
        want <= v;
        repeat (8) @(posedge clk_i);
    endtask
    // One-cycle event pulse
    task pu(input int b);
        @(posedge clk_i);
        pl[b] <= 1;
        @(posedge clk_i);
        pl[b] <= 0;
        repeat (6) @(posedge clk_i);
    endtask
    task final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Cuts a hang short
    initial begin
        #100000;
        errors++;
        final_report;
    end
    initial begin
        sys_rst_i = 1; want = 0; pl = 0; kl = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
        awa = 0; ara = 0; wd = 0;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 0;
        axr(`RSC_OFF_CTRL, 0); chk("ctrl", d, 32'h06);
        axr(`RSC_OFF_SRC, 0); chk("src", d, 32'h30);
        axr(`RSC_OFF_DISP, 0); chk("disp", d, 32'h65);
        axr(`RSC_OFF_STAT, 0); chk("stat", d, 32'h40);
        axr(8'h18, 2'h2); chk("unmapped", d, 0);
        axw(`RSC_OFF_STAT, 0, 2'h2);
        pins(5'h0C); pins(5'h0D); chk("run", run, 1);
        pins(5'h0F); chk("rev", rev, 1);
        pins(5'h0E); chk("rev", rev, 0);
        pins(5'h06); chk("run", run, 0);
        pins(5'h0E); chk("run", run, 0);
        pins(5'h0F); chk("run", run, 1);
        pins(5'h0B); chk("run", run, 0);
        pins(5'h0A); chk("run", run, 0);
        pins(5'h0E); pu(3); chk("run", run, 0);
        pins(5'h0F); pu(0); chk("trip", trip, 1);
        pins(5'h1F); chk("trip", trip, 0);
        chk("run", run, 0);
        pu(0); pu(6); chk("trip", trip, 1);
        pu(2); chk("trip", trip, 0);
        for (i = 0; i < 4; i++) begin
            axw(`RSC_OFF_QIN, qi[i], 0);
            axr(`RSC_OFF_QOUT, 0); chk("quant", d, qe[i]);
        end
        pins(5'h0C); axw(`RSC_OFF_CTRL, 32'h07, 0);
        pins(5'h0D); chk("run", run, 1);
        pins(5'h0F); chk("run", run, 0);
        pins(5'h0D); pu(0); chk("run", run, 0);
        pins(5'h1D); chk("run", run, 1);
        pu(0); pu(1); chk("trip", trip, 0);
        axw(`RSC_OFF_SRC, 32'h31, 0); pu(0); pu(1); chk("trip", trip, 1);
        axw(`RSC_OFF_SRC, 32'h30, 0); pins(5'h0D); pu(1); chk("trip", trip, 1);
        pins(5'h1D); pins(5'h0D); chk("run", run, 1);
        pins(5'h09); chk("run", run, 0);
        @(posedge clk_i); kl <= 3'h1; @(posedge clk_i); kl <= 3'h0;
        repeat (4) @(posedge clk_i); chk("pref", pref, 0);
        repeat (60) @(posedge clk_i); chk("pref", pref, 1);
        @(posedge clk_i); kl <= 3'h7; repeat (16) @(posedge clk_i); kl <= 3'h0;
        axr(`RSC_OFF_STAT, 0); chk("dispoff", d[5], 1);
        axw(`RSC_OFF_CTRL, 32'h17, 0);
        axr(`RSC_OFF_STAT, 0); chk("dispoff", d[5], 0);
        @(posedge clk_i); kl <= 3'h1; @(posedge clk_i); kl <= 3'h0;
        repeat (60) @(posedge clk_i); chk("pref", pref, 1);
        axw(`RSC_OFF_CTRL, 32'h0F, 0); pins(5'h09); chk("trip", trip, 1);
        pu(2); chk("trip", trip, 0);
        final_report;
    end
endmodule // rsc_ctrl_tb
bind rsc_ctrl rsc_ctrl_asserts #(.IDLE_CYC(IDLE_CYC), .HOLD_CYC(HOLD_CYC)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_input_i(enable_input_i),
    .stop_input_i(stop_input_i), .trip_i(trip_i), .key_any_i(key_any_i),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .run_o(run_o), .coast_o(coast_o), .soft_stop_o(soft_stop_o), .trip_o(trip_o),
    .pref_view_o(pref_view_o));

// file: bench/rsc_pins_model.sv
`timescale 1ns/1ps
// Switch bank or PLC outputs; contacts change off the clock edge
module rsc_pins_model (
    input wire clk_i, // Paces the requests only
    input wire [4:0] want_i, // Wanted levels: fwd rev enable stop reset
    output reg [4:0] pin_o // Levels on the discrete pins
);
    initial pin_o = 5'h00;
    // Stop role is wired and driven, so edge starts can be stopped
    always @(posedge clk_i) begin
        pin_o <= #1.3 want_i;
    end
endmodule // rsc_pins_model

// file: hdl/rsc_ctrl.v
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_ctrl #(
    parameter [63:0] IDLE_CYC = `RSC_IDLE_CYC, // Keypad idle period in cycles
    parameter [63:0] HOLD_CYC = `RSC_HOLD_CYC  // Key hold period in cycles
) (
    input wire clk_i, // 200 MHz clock
    input wire sys_rst_i, // Async reset, active high
    input wire run_forward_input_i, // Run forward pin
    input wire run_reverse_input_i, // Run reverse pin
    input wire enable_input_i, // Enable pin
    input wire stop_input_i, // Stop pin, low stops
    input wire fourth_discrete_input_i, // Reset pin
    input wire trip_i, // Trip event from protection logic
    input wire key_any_i, // Any keypad key pressed
    input wire key_toggle_i, // Toggle key held
    input wire key_stopreset_i, // Stop/reset key held
    input wire key_reset_i, // Keypad reset pulse
    input wire key_run_fwd_i, // Keypad run forward pulse
    input wire key_run_rev_i, // Keypad run reverse pulse
    input wire key_stop_i, // Keypad stop pulse
    input wire com_reset_i, // Serial reset pulse
    input wire com_run_fwd_i, // Serial run forward pulse
    input wire com_run_rev_i, // Serial run reverse pulse
    input wire com_stop_i, // Serial stop pulse
    input wire autoreset_req_i, // Autoreset request from counters
    input wire s_axi_awvalid, // AXI write address valid
    output reg s_axi_awready, // AXI write address ready
    input wire [7:0] s_axi_awaddr, // AXI write address
    input wire s_axi_wvalid, // AXI write data valid
    output reg s_axi_wready, // AXI write data ready
    input wire [31:0] s_axi_wdata, // AXI write data
    input wire [3:0] s_axi_wstrb, // AXI byte strobes
    output reg s_axi_bvalid, // AXI write response valid
    input wire s_axi_bready, // AXI write response ready
    output reg [1:0] s_axi_bresp, // AXI write response
    input wire s_axi_arvalid, // AXI read address valid
    output reg s_axi_arready, // AXI read address ready
    input wire [7:0] s_axi_araddr, // AXI read address
    output reg s_axi_rvalid, // AXI read data valid
    input wire s_axi_rready, // AXI read data ready
    output reg [31:0] s_axi_rdata, // AXI read data
    output reg [1:0] s_axi_rresp, // AXI read response
    output reg run_o, // Drive motor
    output reg reverse_o, // Direction, high is reverse
    output reg coast_o, // Coast pulse, drive removed
    output reg soft_stop_o, // Stop by configured method pulse
    output reg trip_o, // Tripped state
    output reg pref_view_o // Display shows preferred view
);
    // Control states; trip dominates stop, stop dominates start
    localparam [1:0] ST_IDLE = 2'h0; // Stopped, ready
    localparam [1:0] ST_RUN = 2'h1;  // Running
    localparam [1:0] ST_TRIP = 2'h2; // Tripped
    // Two-stage synchronisers for five pins
    reg [4:0] sync1_r; // First stage
    reg [4:0] sync2_r; // Second stage
    reg [4:0] prev_r; // Previous synchronised value
    // Configuration registers
    reg [4:0] ctrl_r; // Mode and assignment bits
    reg [7:0] src_r; // Run and reset source codes
    reg [7:0] disp_r; // First/second line selection
    reg [15:0] qin_r; // Value to quantise
    reg [15:0] qout_r; // Quantised value
    reg trip_pend_r; // Software trip request
    reg [1:0] state_r; // Control state
    reg [1:0] state_nxt; // Next state
    reg dir_r; // Commanded direction
    reg dir_nxt; // Next direction
    reg disp_off_r; // Auto return disabled
    // Timers are wide enough for the full minutes-long idle period
    reg [63:0] idle_cnt_r; // Keypad idle counter
    reg [63:0] hold_cnt_r; // Key hold counter
    reg have_aw_r; // Write address captured
    reg have_w_r; // Write data captured
    reg [7:0] aw_r; // Captured write address
    reg [31:0] wd_r; // Captured write data
    // Synchronised pin views; all come from the second stage
    wire fwd_s = sync2_r[0]; // Synchronised run forward
    wire rev_s = sync2_r[1]; // Synchronised run reverse
    wire ena_pin = sync2_r[2]; // Synchronised enable
    wire stp_pin = sync2_r[3]; // Synchronised stop
    wire rst_s = sync2_r[4]; // Synchronised reset
    // Mode and role decode; an unassigned role reads as closed
    wire level_m = ctrl_r[`RSC_CTRL_LEVEL]; // Level start mode
    wire ena = ctrl_r[`RSC_CTRL_EN_ASSIGNED] ? ena_pin : 1'b1;
    wire stp_ok = ctrl_r[`RSC_CTRL_STOP_ASSIGNED] ? stp_pin : 1'b1; // Stop closed
    wire [4:0] tgl = sync2_r ^ prev_r; // Any transition
    // Run codes outside the listed ones select no command source
    wire [3:0] run_src = src_r[3:0]; // Run source code
    wire [3:0] rst_src = src_r[7:4]; // Reset source code
    wire remote = (run_src == `RSC_RUN_REMOTE);
    wire keyb = (run_src == 4'h1) || (run_src == 4'h5) || (run_src == 4'h6); // Keypad
    wire com = (run_src == 4'h2); // Serial
    // reset source codes 0 to 5 pick pin, keypad, serial or a mix of them; other codes pick none
    wire rs_pin = (rst_src == 4'h0) || (rst_src == 4'h3) || (rst_src == 4'h5);
    wire rs_key = (rst_src == 4'h1) || (rst_src == 4'h3) || (rst_src == 4'h4)
        || (rst_src == 4'h5);
    wire rs_com = (rst_src == 4'h2) || (rst_src == 4'h4) || (rst_src == 4'h5);
    // Trip clears on a pin edge, a keypad or serial pulse, or an autoreset
    // request while the reset pin is held high and the pins command the motor
    wire pin_reset = rs_pin && rst_s && !prev_r[4];
    wire autorst_ok = rs_pin && rst_s && remote;
    wire do_reset = pin_reset || (rs_key && key_reset_i) || (rs_com && com_reset_i)
        || (autorst_ok && autoreset_req_i);
    // Edge mode: either transition activates; level mode: held high
    wire e_fwd = remote ? tgl[0] : (keyb ? key_run_fwd_i : (com && com_run_fwd_i));
    wire e_rev = remote ? tgl[1] : (keyb ? key_run_rev_i : (com && com_run_rev_i));
    // Level mode: exactly one run input high selects the direction
    wire l_fwd = fwd_s && !rev_s;
    wire l_rev = rev_s && !fwd_s;
    wire both = fwd_s && rev_s;
    wire ext_stop = (keyb && key_stop_i) || (com && com_stop_i);
    wire lvl = level_m && remote; // Level rules apply to pins only
    // Coast is flagged where the machine leaves run with enable open
    // Write commits once both halves are held and no response waits
    wire wr_fire = have_aw_r && have_w_r && !s_axi_bvalid; // Write ready to commit
    // Next-state logic for the run/stop/trip machine
    always @* begin
        state_nxt = state_r;
        dir_nxt = dir_r;
        case (state_r)
            ST_IDLE: begin
                // Trip first, then interlocks, then start requests
                if (trip_i || trip_pend_r) begin
                    state_nxt = ST_TRIP;
                end else if (!ena || !stp_ok || ext_stop) begin
                    state_nxt = ST_IDLE;
                end else if (lvl) begin
                    if (l_fwd || l_rev) begin
                        state_nxt = ST_RUN;
                        dir_nxt = l_rev;
                    end
                end else if (e_rev) begin
                    state_nxt = ST_RUN;
                    dir_nxt = 1'b1;
                end else if (e_fwd) begin
                    state_nxt = ST_RUN;
                    dir_nxt = 1'b0;
                end
            end
            ST_RUN: begin
                // Any interlock opening ends the run
                if (trip_i || trip_pend_r) begin
                    state_nxt = ST_TRIP;
                end else if (!ena || !stp_ok || ext_stop) begin
                    state_nxt = ST_IDLE;
                end else if (lvl) begin
                    if (both || (!fwd_s && !rev_s)) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        dir_nxt = l_rev;
                    end
                end else if (e_rev) begin
                    dir_nxt = 1'b1;
                end else if (e_fwd) begin
                    dir_nxt = 1'b0;
                end
            end
            ST_TRIP: begin
                // A trip arriving with the clear keeps the trip
                if (do_reset && !trip_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end
    // Synchronisers and previous-value registers
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r <= 5'h00;
        end else begin
            // Pin order: reset, stop, enable, reverse, forward
            sync1_r <= {fourth_discrete_input_i, stop_input_i, enable_input_i,
                run_reverse_input_i, run_forward_input_i};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    // Control state and motor outputs
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            dir_r <= 1'b0;
            run_o <= 1'b0;
            reverse_o <= 1'b0;
            coast_o <= 1'b0;
            soft_stop_o <= 1'b0;
            trip_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dir_r <= dir_nxt;
            run_o <= (state_nxt == ST_RUN);
            reverse_o <= dir_nxt;
            trip_o <= (state_nxt == ST_TRIP);
            // Exit pulses tell a coast from a stop by the configured method
            coast_o <= (state_r == ST_RUN) && (state_nxt != ST_RUN) && !ena;
            soft_stop_o <= (state_r == ST_RUN) && (state_nxt == ST_IDLE) && ena;
        end
    end
    // Keypad idle and hold timers, preferred view
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_cnt_r <= 64'h0;
            hold_cnt_r <= 64'h0;
            disp_off_r <= 1'b0;
            pref_view_o <= 1'b1;
        end else begin
            if (key_any_i) begin
                idle_cnt_r <= 64'h0;
                pref_view_o <= 1'b0;
            end else if (idle_cnt_r < IDLE_CYC - 64'd1) begin
                idle_cnt_r <= idle_cnt_r + 64'd1;
            end else if (!disp_off_r) begin
                pref_view_o <= 1'b1;
            end
            // Clear comes first so a hold completing in the same cycle wins
            if (wr_fire && aw_r == `RSC_OFF_CTRL && wd_r[`RSC_CTRL_CLR_DISP_OFF]) begin
                disp_off_r <= 1'b0;
            end
            // Hold timer runs only while both keys are down
            if (!(key_toggle_i && key_stopreset_i)) begin
                hold_cnt_r <= 64'h0;
            end else if (hold_cnt_r < HOLD_CYC - 64'd1) begin
                hold_cnt_r <= hold_cnt_r + 64'd1;
            end else begin
                disp_off_r <= 1'b1;
            end
        end
    end
    // Truncate to three significant digits by step size
    function [15:0] q3;
        input [15:0] v;
        begin
            // Truncates toward zero; values below 1000 are already exact
            if (v < 16'd1000) begin
                q3 = v;
            end else if (v < 16'd10000) begin
                q3 = v - (v % 16'd10);
            end else begin
                q3 = v - (v % 16'd100);
            end
        end
    endfunction
    // AXI4-Lite write channel and configuration
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            aw_r <= 8'h00;
            wd_r <= 32'h0;
            ctrl_r <= `RSC_CTRL_RST;
            src_r <= `RSC_SRC_RST;
            disp_r <= `RSC_DISP_RST;
            qin_r <= 16'h0;
            qout_r <= 16'h0;
            trip_pend_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_r <= s_axi_awaddr;
                have_aw_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_r <= s_axi_wdata;
                have_w_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Software trip request lasts until the machine has tripped
            if (state_r == ST_TRIP) begin
                trip_pend_r <= 1'b0;
            end
            // Commit once address and data are both held; response follows
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                have_aw_r <= 1'b0;
                have_w_r <= 1'b0;
                if (aw_r == `RSC_OFF_CTRL) begin
                    ctrl_r[2:0] <= wd_r[2:0];
                    if (wd_r[`RSC_CTRL_TRIP_SET]) begin
                        trip_pend_r <= 1'b1;
                    end
                end else if (aw_r == `RSC_OFF_SRC) begin
                    src_r <= wd_r[7:0];
                end else if (aw_r == `RSC_OFF_DISP) begin
                    disp_r <= wd_r[7:0];
                end else if (aw_r == `RSC_OFF_QIN) begin
                    qin_r <= wd_r[15:0];
                    qout_r <= q3(wd_r[15:0]);
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end
            // Reopen both channels only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // AXI4-Lite read channel
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            // Data is registered in the cycle the address is taken
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (s_axi_araddr == `RSC_OFF_CTRL) begin
                    s_axi_rdata <= {27'h0, ctrl_r};
                end else if (s_axi_araddr == `RSC_OFF_SRC) begin
                    s_axi_rdata <= {24'h0, src_r};
                end else if (s_axi_araddr == `RSC_OFF_STAT) begin
                    s_axi_rdata <= {25'h0, pref_view_o, disp_off_r, coast_o,
                        autorst_ok, trip_o, reverse_o, run_o};
                end else if (s_axi_araddr == `RSC_OFF_DISP) begin
                    s_axi_rdata <= {24'h0, disp_r};
                end else if (s_axi_araddr == `RSC_OFF_QIN) begin
                    s_axi_rdata <= {16'h0, qin_r};
                end else if (s_axi_araddr == `RSC_OFF_QOUT) begin
                    s_axi_rdata <= {16'h0, qout_r};
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            end
            // Reopen the address channel once the data is taken
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // rsc_ctrl

// file: include/rsc_defs.vh
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// Register byte offsets
`define RSC_OFF_CTRL 8'h00
`define RSC_OFF_SRC 8'h04
`define RSC_OFF_STAT 8'h08
`define RSC_OFF_DISP 8'h0C
`define RSC_OFF_QIN 8'h10
`define RSC_OFF_QOUT 8'h14
// Control register fields
`define RSC_CTRL_LEVEL 0
`define RSC_CTRL_EN_ASSIGNED 1
`define RSC_CTRL_STOP_ASSIGNED 2
`define RSC_CTRL_TRIP_SET 3
`define RSC_CTRL_CLR_DISP_OFF 4
`define RSC_CTRL_RST 5'h06
// Source register fields
`define RSC_SRC_RUN_LSB 0
`define RSC_SRC_RST_LSB 4
`define RSC_SRC_RST 8'h30
`define RSC_RUN_REMOTE 4'h0
// Status bits
`define RSC_ST_RUN 0
`define RSC_ST_REV 1
`define RSC_ST_TRIP 2
`define RSC_ST_AUTORST 3
`define RSC_ST_COAST 4
`define RSC_ST_DISPOFF 5
`define RSC_ST_PREF 6
// Display defaults
`define RSC_DISP_RST 8'h65
// Timing
`define RSC_CLK_MHZ 200
`define RSC_IDLE_S 300
`define RSC_HOLD_S 5
`define RSC_IDLE_CYC (`RSC_IDLE_S * `RSC_CLK_MHZ * 64'd1000000)
`define RSC_HOLD_CYC (`RSC_HOLD_S * `RSC_CLK_MHZ * 64'd1000000)
`endif
